//--- hdl/prot_cmd_device.sv
// Device end: decodes protection, lock and password commands from the link.
// Assumes the link clock is far slower than the system clock (8+ cycles a phase).
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Protection read returns sector's 8-bit value
// - Address length from config bit or opcode
// - Protection read repeats same byte every eight
// - Host sends sector base, high bits zero
// - Protection program needs write enable first
// - Program starts only at chip-select after address
// - Busy while self-timed; completion clears write enable
// - Protection program sets busy, error like programming
// - Erase sets all protection bits to one
// - Erase suspend refused during protection erase
// - Lock read repeats, only when idle
// - Lock clear zeroes lock register, self-timed
// - Password read low byte first, repeats
// - Password mode makes password read undefined
// - Password program needs enable, ignored in mode
// - Password program runs after exact 64 bits
// - Unlock compares after exact 64 bits
// - Mismatch sets error, holds busy until cleared
// - Match sets the lock bit
// - Sample on rising, drive on falling edge
// - Busy is status bit zero
module prot_cmd_device (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  prot_spi_if.device spi, // Serial link
  input wire logic addr_len_32, // Address-length configuration bit
  input wire logic pass_mode_sel_n, // Protection-mode bit 2, low = password mode
  input wire logic erase_suspend_req, // Erase-suspend request pulse
  output logic suspend_refused, // Pulse: suspend refused during erase
  output logic busy, // Self-timed operation or error hold
  output logic p_err, // Program error flag
  output logic write_enable_latch, // Write-enable latch
  output logic lock_bit, // Protection lock bit
  output logic [15:0] prot_bits // Per-sector protection, 1 = open
);
  typedef enum logic [1:0] {EX_IDLE, EX_RUN, EX_HOLD} exec_t;
  typedef enum logic [2:0] {J_PROG, J_ERASE, J_LOCK, J_PASS, J_UNLOCK} job_t;

  exec_t ex_q, ex_d;
  job_t job_q, job_d;
  logic [2:0] sy0_q, sy1_q, sy2_q, filt_q, filt_d;
  logic [7:0] cnt_q, cnt_d, op_q, op_d, tmr_q, tmr_d, lock_q, lock_d, status;
  logic [63:0] sh_q, sh_d, out_q, out_d, data_q, data_d, pw_q, pw_d;
  logic [15:0] prot_q, prot_d;
  localparam int SECT_W_L = prot_cmd_pkg::SECT_W;
  logic [SECT_W_L-1:0] sect_q, sect_d;
  logic io1_q, io1_d, rd_q, rd_d, wr_en_q, wr_en_d, perr_q, perr_d, refuse_q, refuse_d;
  logic sck_rise, sck_fall, cs_rise, cs_high, din;
  logic [7:0] alen, hdr;

  // ----------------------------------------------------------------
  // Link inputs {cs_n, sck, io0}: three flops, taken when last two agree
  // ----------------------------------------------------------------
  always_comb begin
    filt_d = (~(sy1_q ^ sy2_q) & sy2_q) | ((sy1_q ^ sy2_q) & filt_q);
    sck_rise = filt_d[1] & ~filt_q[1];
    sck_fall = ~filt_d[1] & filt_q[1];
    cs_rise = filt_d[2] & ~filt_q[2];
    cs_high = filt_d[2];
    din = filt_d[0];
  end

  // Header length of the opcode held in the current frame
  always_comb begin
    alen = (prot_cmd_pkg::op_is_a32(op_q) || addr_len_32) ?
           prot_cmd_pkg::ADDR_BITS_4B : prot_cmd_pkg::ADDR_BITS_3B;
    hdr = prot_cmd_pkg::OPCODE_BITS + alen;
    status = 8'h00;
    status[prot_cmd_pkg::ST_BUSY] = (ex_q != EX_IDLE);
    status[prot_cmd_pkg::ST_WR_EN] = wr_en_q;
    status[prot_cmd_pkg::ST_PERR] = perr_q;
  end

  // ----------------------------------------------------------------
  // Frame decode, read-back shifter and self-timed executor
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    op_d = op_q;
    out_d = out_q;
    io1_d = io1_q;
    rd_d = rd_q;
    ex_d = ex_q;
    job_d = job_q;
    tmr_d = tmr_q;
    sect_d = sect_q;
    data_d = data_q;
    prot_d = prot_q;
    lock_d = lock_q;
    pw_d = pw_q;
    wr_en_d = wr_en_q;
    perr_d = perr_q;
    refuse_d = erase_suspend_req && (ex_q == EX_RUN) && (job_q == J_ERASE);

    // Executor; a new frame can only start a job from idle
    unique case (ex_q)
      EX_IDLE: begin
      end
      EX_RUN: begin
        if (tmr_q != 8'h00) begin
          tmr_d = tmr_q - 8'h01;
        end else begin
          ex_d = EX_IDLE;
          wr_en_d = 1'b0;
          unique case (job_q)
            J_PROG: begin
              // Lock bit clear blocks program but not erase: fail like a protected page
              if (lock_q[prot_cmd_pkg::LOCK_BIT]) begin
                prot_d[sect_q] = 1'b0;
              end else begin
                perr_d = 1'b1;
              end
            end
            J_ERASE: prot_d = prot_cmd_pkg::PROT_RESET;
            J_LOCK: lock_d = 8'h00;
            J_PASS: pw_d = prot_cmd_pkg::bswap64(data_q);
            J_UNLOCK: begin
              // Write enable clears here as for every other job
              if (prot_cmd_pkg::bswap64(data_q) == pw_q) begin
                lock_d[prot_cmd_pkg::LOCK_BIT] = 1'b1;
              end else begin
                perr_d = 1'b1;
                ex_d = EX_HOLD;
              end
            end
          endcase
        end
      end
      EX_HOLD: begin
      end
    endcase

    // Serial side
    if (cs_high) begin
      cnt_d = 8'h00;
      rd_d = 1'b0;
    end else if (sck_rise) begin
      cnt_d = (cnt_q == prot_cmd_pkg::CNT_MAX) ? cnt_q : cnt_q + 8'h01;
      sh_d = {sh_q[62:0], din};
      if (cnt_d == prot_cmd_pkg::OPCODE_BITS) begin
        op_d = sh_d[7:0];
        case (sh_d[7:0])
          prot_cmd_pkg::OP_STATUS_READ: begin
            out_d = {8{status}};
            rd_d = 1'b1;
          end
          prot_cmd_pkg::OP_LOCK_READ: begin
            if (ex_q == EX_IDLE) begin
              out_d = {8{lock_q}};
              rd_d = 1'b1;
            end
          end
          prot_cmd_pkg::OP_PASS_READ: begin
            out_d = pass_mode_sel_n ? prot_cmd_pkg::bswap64(pw_q) :
                    prot_cmd_pkg::UNDEF_DATA;
            rd_d = 1'b1;
          end
          default: begin
          end
        endcase
      end else if ((op_q == prot_cmd_pkg::OP_PROT_READ ||
                    op_q == prot_cmd_pkg::OP_PROT_READ_A32) && cnt_d == hdr) begin
        // Same byte eight times: rotation repeats it every eight clocks
        out_d = {8{prot_q[sh_d[prot_cmd_pkg::SECT_LSB +: SECT_W_L]] ?
                   prot_cmd_pkg::PROT_OPEN : prot_cmd_pkg::PROT_SHUT}};
        rd_d = 1'b1;
      end
    end else if (sck_fall) begin
      io1_d = out_q[63];
      out_d = {out_q[62:0], out_q[63]};
    end

    // Frame end: write-type commands need the exact bit count
    if (cs_rise) begin
      if (ex_q == EX_IDLE && cnt_q == prot_cmd_pkg::OPCODE_BITS &&
          op_q == prot_cmd_pkg::OP_WRITE_ENABLE) begin
        wr_en_d = 1'b1;
      end
      if (ex_q != EX_RUN && cnt_q == prot_cmd_pkg::OPCODE_BITS &&
          op_q == prot_cmd_pkg::OP_CLEAR_STATUS) begin
        perr_d = 1'b0;
        ex_d = EX_IDLE;
      end
      if (ex_q == EX_IDLE) begin
        tmr_d = prot_cmd_pkg::OP_CYC_M1;
        if ((op_q == prot_cmd_pkg::OP_PROT_PROG || op_q == prot_cmd_pkg::OP_PROT_PROG_A32)
            && cnt_q == hdr && wr_en_q) begin
          job_d = J_PROG;
          sect_d = sh_q[prot_cmd_pkg::SECT_LSB +: SECT_W_L];
          ex_d = EX_RUN;
        end
        if (op_q == prot_cmd_pkg::OP_PROT_ERASE && cnt_q == prot_cmd_pkg::OPCODE_BITS
            && wr_en_q) begin
          job_d = J_ERASE;
          ex_d = EX_RUN;
        end
        if (op_q == prot_cmd_pkg::OP_LOCK_CLEAR && cnt_q == prot_cmd_pkg::OPCODE_BITS
            && wr_en_q) begin
          job_d = J_LOCK;
          ex_d = EX_RUN;
        end
        if (op_q == prot_cmd_pkg::OP_PASS_PROG && wr_en_q && pass_mode_sel_n &&
            cnt_q == prot_cmd_pkg::OPCODE_BITS + prot_cmd_pkg::PASS_BITS) begin
          job_d = J_PASS;
          data_d = sh_q;
          ex_d = EX_RUN;
        end
        if (op_q == prot_cmd_pkg::OP_PASS_UNLOCK &&
            cnt_q == prot_cmd_pkg::OPCODE_BITS + prot_cmd_pkg::PASS_BITS) begin
          job_d = J_UNLOCK;
          data_d = sh_q;
          ex_d = EX_RUN;
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sy0_q <= 3'b101;
      sy1_q <= 3'b101;
      sy2_q <= 3'b101;
      filt_q <= 3'b101;
      cnt_q <= 8'h00;
      sh_q <= '0;
      op_q <= 8'h00;
      out_q <= '0;
      io1_q <= 1'b1;
      rd_q <= 1'b0;
      ex_q <= EX_IDLE;
      job_q <= J_PROG;
      tmr_q <= 8'h00;
      sect_q <= '0;
      data_q <= '0;
      prot_q <= prot_cmd_pkg::PROT_RESET;
      lock_q <= prot_cmd_pkg::LOCK_RESET;
      pw_q <= prot_cmd_pkg::PASS_RESET;
      wr_en_q <= 1'b0;
      perr_q <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      sy0_q <= {spi.cs_n, spi.sck, spi.io0};
      sy1_q <= sy0_q;
      sy2_q <= sy1_q;
      filt_q <= filt_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      op_q <= op_d;
      out_q <= out_d;
      io1_q <= io1_d;
      rd_q <= rd_d;
      ex_q <= ex_d;
      job_q <= job_d;
      tmr_q <= tmr_d;
      sect_q <= sect_d;
      data_q <= data_d;
      prot_q <= prot_d;
      lock_q <= lock_d;
      pw_q <= pw_d;
      wr_en_q <= wr_en_d;
      perr_q <= perr_d;
      refuse_q <= refuse_d;
    end
  end

  // Outputs from flops, except busy, which is decoded from ex_q
  assign spi.io1_out = io1_q;
  assign spi.io1_oe = rd_q;
  assign suspend_refused = refuse_q;
  assign busy = (ex_q != EX_IDLE);
  assign p_err = perr_q;
  assign write_enable_latch = wr_en_q;
  assign lock_bit = lock_q[prot_cmd_pkg::LOCK_BIT];
  assign prot_bits = prot_q;
endmodule
`default_nettype wire

//--- hdl/prot_cmd_host.sv
// Host end: frames one command per request and collects read-back bits.
// Assumes the user issues write enable itself before write-type commands.
`timescale 1ns/100ps
`default_nettype none
module prot_cmd_host (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  prot_spi_if.host spi, // Serial link
  input wire logic addr_len_32, // Address-length configuration copy
  input wire logic cmd_valid, // Request strobe
  output logic cmd_ready, // Idle and able to take a request
  input wire logic [7:0] cmd_op, // Opcode
  input wire logic [31:0] cmd_addr, // Sector base address
  input wire logic [63:0] cmd_data, // Password value
  input wire logic [3:0] cmd_rd_bytes, // Bytes to read back, 0 to 8
  output logic rsp_valid, // One-cycle end-of-frame pulse
  output logic [63:0] rsp_data // Read bits, last bit in bit 0
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} hstate_t;

  hstate_t st_q, st_d;
  logic [71:0] tx_q, tx_d;
  logic [63:0] rx_q, rx_d;
  logic [7:0] cnt_q, cnt_d, tot_q, tot_d, nout_q, nout_d, tmr_q, tmr_d;
  logic cs_q, cs_d, sck_q, sck_d, done_q, done_d;
  logic [2:0] sy_q;
  logic filt_q, filt_d;
  logic [7:0] alen;

  // ----------------------------------------------------------------
  // Read-back input: three flops, change taken when last two agree
  // ----------------------------------------------------------------
  always_comb begin
    filt_d = (sy_q[1] == sy_q[2]) ? sy_q[2] : filt_q;
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    tx_d = tx_q;
    rx_d = rx_q;
    cnt_d = cnt_q;
    tot_d = tot_q;
    nout_d = nout_q;
    tmr_d = tmr_q;
    cs_d = cs_q;
    sck_d = sck_q;
    done_d = 1'b0;
    alen = (prot_cmd_pkg::op_is_a32(cmd_op) || addr_len_32) ?
           prot_cmd_pkg::ADDR_BITS_4B : prot_cmd_pkg::ADDR_BITS_3B;
    unique case (st_q)
      H_IDLE: begin
        if (cmd_valid) begin
          // Write enable is left to the user, so gating stays visible
          tx_d = {cmd_op, 64'h0};
          nout_d = prot_cmd_pkg::OPCODE_BITS;
          if (prot_cmd_pkg::op_has_addr(cmd_op)) begin
            // Upper bits are sent exactly as given; user keeps them zero
            tx_d[63:0] = (alen == prot_cmd_pkg::ADDR_BITS_4B) ?
                         {cmd_addr, 32'h0} : {cmd_addr[23:0], 40'h0};
            nout_d = prot_cmd_pkg::OPCODE_BITS + alen;
          end else if (prot_cmd_pkg::op_has_data(cmd_op)) begin
            tx_d[63:0] = prot_cmd_pkg::bswap64(cmd_data);
            nout_d = prot_cmd_pkg::OPCODE_BITS + prot_cmd_pkg::PASS_BITS;
          end
          tot_d = nout_d + {1'b0, cmd_rd_bytes, 3'b000};
          cnt_d = '0;
          rx_d = '0;
          cs_d = 1'b0;
          tmr_d = prot_cmd_pkg::HALF_CYC_M1;
          st_d = H_LOW;
        end
      end
      H_LOW: begin
        if (tmr_q == 8'h00) begin
          sck_d = 1'b1;
          if (cnt_q >= nout_q) begin
            rx_d = {rx_q[62:0], filt_q};
          end
          tmr_d = prot_cmd_pkg::HALF_CYC_M1;
          st_d = H_HIGH;
        end else begin
          tmr_d = tmr_q - 8'h01;
        end
      end
      H_HIGH: begin
        if (tmr_q == 8'h00) begin
          sck_d = 1'b0;
          tx_d = {tx_q[70:0], 1'b0};
          cnt_d = cnt_q + 8'h01;
          tmr_d = prot_cmd_pkg::HALF_CYC_M1;
          st_d = H_LOW;
          if (cnt_d == tot_q) begin
            cs_d = 1'b1;
            st_d = H_GAP;
          end
        end else begin
          tmr_d = tmr_q - 8'h01;
        end
      end
      H_GAP: begin
        if (tmr_q == 8'h00) begin
          done_d = 1'b1;
          st_d = H_IDLE;
        end else begin
          tmr_d = tmr_q - 8'h01;
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= H_IDLE;
      tx_q <= '0;
      rx_q <= '0;
      cnt_q <= '0;
      tot_q <= '0;
      nout_q <= '0;
      tmr_q <= '0;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      done_q <= 1'b0;
      sy_q <= 3'b111;
      filt_q <= 1'b1;
    end else begin
      st_q <= st_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      cnt_q <= cnt_d;
      tot_q <= tot_d;
      nout_q <= nout_d;
      tmr_q <= tmr_d;
      cs_q <= cs_d;
      sck_q <= sck_d;
      done_q <= done_d;
      sy_q <= {sy_q[1:0], spi.io1};
      filt_q <= filt_d;
    end
  end

  assign spi.cs_n = cs_q;
  assign spi.sck = sck_q;
  assign spi.io0 = tx_q[71];
  assign cmd_ready = (st_q == H_IDLE);
  assign rsp_valid = done_q;
  assign rsp_data = rx_q;
endmodule
`default_nettype wire

//--- hdl/prot_cmd_pkg.sv
// Shared constants for the sector-protection and password command pair.
// Assumes a 25 MHz system clock on both ends and single-lane serial IO.
package prot_cmd_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PROT_READ = 8'hfc;
  localparam logic [7:0] OP_PROT_READ_A32 = 8'he2;
  localparam logic [7:0] OP_PROT_PROG = 8'hfd;
  localparam logic [7:0] OP_PROT_PROG_A32 = 8'he3;
  localparam logic [7:0] OP_PROT_ERASE = 8'he4;
  localparam logic [7:0] OP_LOCK_READ = 8'ha7;
  localparam logic [7:0] OP_LOCK_CLEAR = 8'ha6;
  localparam logic [7:0] OP_PASS_READ = 8'he7;
  localparam logic [7:0] OP_PASS_PROG = 8'he8;
  localparam logic [7:0] OP_PASS_UNLOCK = 8'he9;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;

  // ----------------------------------------------------------------
  // Frame lengths, layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPCODE_BITS = 8'h08;
  localparam logic [7:0] ADDR_BITS_3B = 8'h18;
  localparam logic [7:0] ADDR_BITS_4B = 8'h20;
  localparam logic [7:0] PASS_BITS = 8'h40;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam int SECTORS = 16;
  localparam int SECT_LSB = 16;
  localparam int SECT_W = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_WR_EN = 1;
  localparam int ST_PERR = 6;
  localparam int LOCK_BIT = 0;
  localparam logic [7:0] LOCK_RESET = 8'h01;
  localparam logic [15:0] PROT_RESET = 16'hffff;
  localparam logic [63:0] PASS_RESET = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] UNDEF_DATA = 64'hffff_ffff_ffff_ffff;
  localparam logic [7:0] PROT_OPEN = 8'hff;
  localparam logic [7:0] PROT_SHUT = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int OP_TIME_NS = 1280;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_PERIOD_NS = 800;
  localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] OP_CYC_M1 = 8'(OP_CYCLES - 1);
  localparam logic [7:0] HALF_CYC_M1 = 8'(SCK_HALF_CYCLES - 1);

  // ----------------------------------------------------------------
  // Opcode classes and byte order
  // ----------------------------------------------------------------
  function automatic logic op_is_a32(input logic [7:0] op);
    return (op == OP_PROT_READ_A32) || (op == OP_PROT_PROG_A32);
  endfunction

  function automatic logic op_has_addr(input logic [7:0] op);
    return (op == OP_PROT_READ) || (op == OP_PROT_PROG) || op_is_a32(op);
  endfunction

  function automatic logic op_has_data(input logic [7:0] op);
    return (op == OP_PASS_PROG) || (op == OP_PASS_UNLOCK);
  endfunction

  // Low byte first on the wire, bits of each byte high first
  function automatic logic [63:0] bswap64(input logic [63:0] v);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[8*i +: 8] = v[56-8*i +: 8];
    end
    return r;
  endfunction
endpackage

//--- hdl/prot_spi_if.sv
// Serial link between host controller and protected flash command logic.
// Assumes io1 idles high when the device does not drive it.
`timescale 1ns/100ps
`default_nettype none
interface prot_spi_if;
  logic cs_n;
  logic sck;
  logic io0;
  logic io1_out;
  logic io1_oe;
  logic io1;

  // ----------------------------------------------------------------
  // Wire level: pulled high when released
  // ----------------------------------------------------------------
  assign io1 = io1_oe ? io1_out : 1'b1;

  modport host (output cs_n, output sck, output io0, input io1);
  modport device (input cs_n, input sck, input io0, output io1_out, output io1_oe);
endinterface
`default_nettype wire

//--- verification/prot_link_monitor.sv
// Checker for the serial link between the two ends and the device flags.
// Assumes it sits beside the interface that joins host and device ends.
`timescale 1ns/100ps
`default_nettype none
module prot_link_monitor (
  input wire logic clock, // System clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic cs_n, // Chip select
  input wire logic sck, // Link clock
  input wire logic io0, // Host data
  input wire logic io1_out, // Device data
  input wire logic io1_oe, // Device drive enable
  input wire logic busy, // Busy flag
  input wire logic write_enable_latch, // Write-enable latch
  input wire logic p_err, // Program error flag
  input wire logic lock_bit // Lock bit
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Link framing and edges
  // ----------------------------------------------------------------
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("sck high outside a frame");
  sck_phase_a: assert property ($rose(sck) |-> sck [*8])
    else $error("sck high phase too short");
  in_stable_a: assert property ($changed(io0) |-> !sck)
    else $error("io0 moved while sck high");
  // Device may only move its bit in the low phase, after the falling edge
  out_fall_a: assert property (io1_oe && $past(io1_oe) && $changed(io1_out) |-> !sck)
    else $error("io1 moved while sck high");
  oe_idle_a: assert property (cs_n [*8] |-> !io1_oe)
    else $error("io1 driven outside a frame");

  // ----------------------------------------------------------------
  // Self-timed jobs and flags
  // ----------------------------------------------------------------
  busy_start_a: assert property ($rose(busy) |-> cs_n)
    else $error("job started inside a frame");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("busy pulse too short");
  wr_en_clear_a: assert property ($fell(busy) |-> !write_enable_latch)
    else $error("write enable left set after job");
  wr_en_set_a: assert property ($rose(write_enable_latch) |-> cs_n && !busy)
    else $error("write enable set at wrong time");
  lock_clear_a: assert property ($fell(lock_bit) |-> $past(busy))
    else $error("lock bit cleared outside a job");
  err_set_a: assert property ($rose(p_err) |-> $past(busy))
    else $error("error flag set outside a job");
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Bench: host and device ends joined on one link, driven by host requests.
// Assumes package, interface and both ends are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic addr_len_32 = 1'b0;
  logic pass_mode_sel_n = 1'b1;
  logic erase_suspend_req = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic [31:0] cmd_addr = 32'h0;
  logic [63:0] cmd_data = 64'h0;
  logic [3:0] cmd_rd_bytes = 4'h0;
  logic cmd_ready, rsp_valid, suspend_refused, busy, p_err, write_enable_latch, lock_bit;
  logic [63:0] rsp_data, rd;
  logic [15:0] prot_bits;
  logic seen_refuse = 1'b0;
  int fail_count = 0;
  int tests_run = 0;
  int busy_len = 0;
  int last_len = 0;
  localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] PW_WIRE = 64'hefcd_ab89_6745_2301; // Low byte read first

  always #20 clock = ~clock;

  prot_spi_if spi ();
  prot_cmd_host i_prot_cmd_host (.clock(clock), .rst_n(rst_n), .spi(spi),
    .addr_len_32(addr_len_32), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_rd_bytes(cmd_rd_bytes), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  prot_cmd_device i_prot_cmd_device (.clock(clock), .rst_n(rst_n), .spi(spi),
    .addr_len_32(addr_len_32), .pass_mode_sel_n(pass_mode_sel_n),
    .erase_suspend_req(erase_suspend_req), .suspend_refused(suspend_refused),
    .busy(busy), .p_err(p_err), .write_enable_latch(write_enable_latch), .lock_bit(lock_bit),
    .prot_bits(prot_bits));
  prot_link_monitor i_prot_link_monitor (.clock(clock), .rst_n(rst_n), .cs_n(spi.cs_n),
    .sck(spi.sck), .io0(spi.io0), .io1_out(spi.io1_out), .io1_oe(spi.io1_oe),
    .busy(busy), .write_enable_latch(write_enable_latch), .p_err(p_err), .lock_bit(lock_bit));

  // Length of each busy pulse, kept for the self-timed duration check
  always @(posedge clock) begin
    if (busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end else begin
      if (busy_len != 0) begin
        last_len <= busy_len;
      end
      busy_len <= 0;
    end
    if (suspend_refused === 1'b1) begin
      seen_refuse <= 1'b1;
    end
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One host request; held until taken, then wait for the end-of-frame pulse
  task automatic cmd(input logic [7:0] op, input logic [31:0] addr, input logic [63:0] data,
                     input logic [3:0] nb);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = addr;
    cmd_data = data;
    cmd_rd_bytes = nb;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("response", {63'h0, rsp_valid}, 64'h1);
    rd = rsp_data;
  endtask

  task automatic write_en;
    cmd(prot_cmd_pkg::OP_WRITE_ENABLE, 32'h0, 64'h0, 4'h0);
  endtask

  // Bounded wait for a self-timed job; a held mismatch simply runs out
  task automatic settle;
    int n;
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge clock);
      #1;
      n++;
    end
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check("reset flags", {busy, write_enable_latch, p_err, lock_bit, prot_bits},
          20'h1ffff);
    cmd(prot_cmd_pkg::OP_PROT_PROG, 32'h0003_0000, 64'h0, 4'h0);
    settle;
    check("prog without enable", {write_enable_latch, busy, prot_bits}, 18'h0ffff);
    write_en;
    // One byte too many after the address: the device must drop the program
    cmd(prot_cmd_pkg::OP_PROT_PROG, 32'h0003_0000, 64'h0, 4'h1);
    settle;
    check("overlong prog", {write_enable_latch, busy, prot_bits}, 18'h2ffff);
    write_en;
    cmd(prot_cmd_pkg::OP_STATUS_READ, 32'h0, 64'h0, 4'h1);
    check("status after enable", rd, 64'h02);
    cmd(prot_cmd_pkg::OP_PROT_PROG, 32'h0003_0000, 64'h0, 4'h0);
    settle;
    check("busy cycles", 64'(last_len >= 32 && last_len <= 33), 64'h1);
    check("prog sector", {write_enable_latch, prot_bits}, 17'h0fff7);
    addr_len_32 = 1'b1;
    write_en;
    cmd(prot_cmd_pkg::OP_PROT_PROG, 32'h0005_0000, 64'h0, 4'h0);
    settle;
    addr_len_32 = 1'b0;
    write_en;
    cmd(prot_cmd_pkg::OP_PROT_PROG_A32, 32'h0006_0000, 64'h0, 4'h0);
    settle;
    check("address lengths", prot_bits, 16'hff97);
    cmd(prot_cmd_pkg::OP_PROT_READ, 32'h0005_0000, 64'h0, 4'h2);
    check("read shut twice", rd, 64'h0000);
    cmd(prot_cmd_pkg::OP_PROT_READ_A32, 32'h0004_0000, 64'h0, 4'h2);
    check("read open twice", rd, 64'hffff);
    write_en;
    cmd(prot_cmd_pkg::OP_PROT_ERASE, 32'h0, 64'h0, 4'h0);
    erase_suspend_req = 1'b1;
    @(posedge clock);
    #1;
    erase_suspend_req = 1'b0;
    settle;
    check("suspend refused", {63'h0, seen_refuse}, 64'h1);
    check("erase all", prot_bits, 16'hffff);
    cmd(prot_cmd_pkg::OP_LOCK_READ, 32'h0, 64'h0, 4'h2);
    check("lock read", rd, 64'h0101);
    write_en;
    cmd(prot_cmd_pkg::OP_LOCK_CLEAR, 32'h0, 64'h0, 4'h0);
    settle;
    cmd(prot_cmd_pkg::OP_LOCK_READ, 32'h0, 64'h0, 4'h1);
    check("lock cleared", {lock_bit, rd[7:0]}, 9'h000);
    write_en;
    cmd(prot_cmd_pkg::OP_PROT_PROG, 32'h0002_0000, 64'h0, 4'h0);
    settle;
    check("prog while locked", {p_err, prot_bits}, 17'h1ffff);
    cmd(prot_cmd_pkg::OP_CLEAR_STATUS, 32'h0, 64'h0, 4'h0);
    settle;
    check("error cleared", {63'h0, p_err}, 64'h0);
    write_en;
    cmd(prot_cmd_pkg::OP_PASS_PROG, 32'h0, PW, 4'h0);
    settle;
    check("pass prog done", {write_enable_latch, busy}, 2'b00);
    cmd(prot_cmd_pkg::OP_PASS_READ, 32'h0, 64'h0, 4'h8);
    check("pass read order", rd, PW_WIRE);
    cmd(prot_cmd_pkg::OP_PASS_UNLOCK, 32'h0, PW ^ 64'h1, 4'h0);
    settle;
    check("mismatch hold", {busy, p_err}, 2'b11);
    cmd(prot_cmd_pkg::OP_STATUS_READ, 32'h0, 64'h0, 4'h1);
    check("status in hold", rd, 64'h41);
    cmd(prot_cmd_pkg::OP_CLEAR_STATUS, 32'h0, 64'h0, 4'h0);
    settle;
    check("hold released", {busy, p_err}, 2'b00);
    cmd(prot_cmd_pkg::OP_PASS_UNLOCK, 32'h0, PW, 4'h0);
    settle;
    check("unlock match", {p_err, lock_bit}, 2'b01);
    pass_mode_sel_n = 1'b0;
    cmd(prot_cmd_pkg::OP_PASS_READ, 32'h0, 64'h0, 4'h8);
    check("pass read hidden", rd, prot_cmd_pkg::UNDEF_DATA);
    write_en;
    cmd(prot_cmd_pkg::OP_PASS_PROG, 32'h0, 64'h0, 4'h0);
    settle;
    check("pass prog ignored", {write_enable_latch, busy}, 2'b10);
    pass_mode_sel_n = 1'b1;
    cmd(prot_cmd_pkg::OP_PASS_READ, 32'h0, 64'h0, 4'h8);
    check("password kept", rd, PW_WIRE);
    wrap_up;
  end

  // Watchdog: well beyond the expected run of about 20,000 cycles
  initial begin
    #2000000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
